// ---- src/qex_target.sv ----
// expander end: two-wire target, software reset, identity read, 16 quasi pins
// assumes scl and sda arrive asynchronous to i_core_clk and are oversampled
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module qex_target #(
    parameter logic [7:0] P_MFR_ID = 8'h5a,   // arbitrary value
    parameter logic [12:0] P_PART_ID = 13'h0123, // arbitrary value
    parameter logic [2:0] P_REV_ID = 3'h1     // arbitrary value
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // bus
    qex_if.target bus,
    // straps and reset pin
    input wire logic [6:0] i_own_addr,
    input wire logic i_reset_n,
    // port pins
    input wire logic [15:0] i_port_in,
    output logic [15:0] o_port_o,
    output logic [15:0] o_port_oe_n,
    output logic [15:0] o_strong_pullup
);

    ////////////////////////////////////////////////////////////////////////////////
    // input sampling: three flops, change taken when second and third agree
    logic [18:0] raw_w;
    logic [18:0] s1_r;
    logic [18:0] s2_r;
    logic [18:0] s3_r;
    logic [18:0] flt_r;
    logic [18:0] agree_w;
    logic scl_q_r;
    logic sda_q_r;

    assign raw_w = {i_reset_n, i_port_in, bus.scl, bus.sda};
    assign agree_w = ~(s2_r ^ s3_r);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            flt_r <= '1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            s1_r <= raw_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= (agree_w & s3_r) | (~agree_w & flt_r);
            scl_q_r <= flt_r[1];
            sda_q_r <= flt_r[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus events
    logic sda_w;
    logic scl_w;
    logic rstn_w;
    logic [15:0] pins_w;
    logic scl_rise_w;
    logic scl_fall_w;
    logic start_w;
    logic stop_w;

    assign sda_w = flt_r[0];
    assign scl_w = flt_r[1];
    assign pins_w = flt_r[17:2];
    assign rstn_w = flt_r[18];
    assign scl_rise_w = scl_w & ~scl_q_r;
    assign scl_fall_w = ~scl_w & scl_q_r;
    assign start_w = scl_w & scl_q_r & ~sda_w & sda_q_r;
    assign stop_w = scl_w & scl_q_r & sda_w & ~sda_q_r;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    qex_pkg::qex_tstate_t st_r;
    qex_pkg::qex_tstate_t nxt_w;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic ack_ph_r;
    logic data_ph_r;
    logic sda_low_r;
    logic nack_r;
    logic pair_r;
    logic [1:0] id_idx_r;
    logic gc_armed_r;
    logic id_armed_r;
    logic [15:0] port_r;
    logic [15:0] strong_r;

    ////////////////////////////////////////////////////////////////////////////////
    // decode
    logic soft_rst_w;
    logic clr_w;
    logic tx_st_w;
    logic gc_hit_w;
    logic own_hit_w;
    logic idw_hit_w;
    logic idr_hit_w;
    logic ack_w;
    logic ack_in_w;
    logic ack_end_w;
    logic wr_evt_w;
    logic [23:0] id_word_w;
    logic [7:0] id_byte_w;
    logic [7:0] tx_byte_w;
    logic [15:0] wr_mask_w;

    assign soft_rst_w = stop_w & gc_armed_r;
    assign clr_w = ~rstn_w | soft_rst_w;
    assign tx_st_w = (st_r == qex_pkg::TS_RD) | (st_r == qex_pkg::TS_IDRD);
    assign gc_hit_w = (sh_r == qex_pkg::GC_WR_BYTE);
    assign own_hit_w = (sh_r[7:1] == i_own_addr);
    assign idw_hit_w = (sh_r == {qex_pkg::ID_ADDR, 1'b0});
    assign idr_hit_w = (sh_r == {qex_pkg::ID_ADDR, 1'b1}) & id_armed_r;
    assign ack_in_w = scl_fall_w & (bit_r == qex_pkg::ACK_BIT) & ~ack_ph_r;
    assign ack_end_w = scl_fall_w & ack_ph_r;
    assign wr_evt_w = ack_end_w & (st_r == qex_pkg::TS_WR) & data_ph_r;
    assign wr_mask_w = pair_r ? {sh_r, 8'h00} : {8'h00, sh_r};

    assign id_word_w = {P_MFR_ID, P_PART_ID, P_REV_ID};
    assign id_byte_w = (id_idx_r == 2'h0) ? id_word_w[23:16] :
                       (id_idx_r == 2'h1) ? id_word_w[15:8] : id_word_w[7:0];
    assign tx_byte_w = (st_r == qex_pkg::TS_IDRD) ? id_byte_w :
                       (pair_r ? pins_w[15:8] : pins_w[7:0]);

    // acknowledge decision and following state at the end of a received byte
    always_comb begin
        ack_w = 1'b0;
        nxt_w = qex_pkg::TS_IGN;
        case (st_r)
            qex_pkg::TS_ADDR: begin
                if (gc_hit_w) begin
                    ack_w = 1'b1;
                    nxt_w = qex_pkg::TS_GC;
                end else if (idw_hit_w) begin
                    ack_w = 1'b1;
                    nxt_w = qex_pkg::TS_IDTGT;
                end else if (idr_hit_w) begin
                    ack_w = 1'b1;
                    nxt_w = qex_pkg::TS_IDRD;
                end else if (own_hit_w) begin
                    ack_w = 1'b1;
                    nxt_w = sh_r[0] ? qex_pkg::TS_RD : qex_pkg::TS_WR;
                end
            end
            qex_pkg::TS_GC: begin
                ack_w = (sh_r == qex_pkg::SWRST_BYTE);
            end
            qex_pkg::TS_WR: begin
                ack_w = 1'b1;
                nxt_w = qex_pkg::TS_WR;
            end
            qex_pkg::TS_IDTGT: begin
                ack_w = own_hit_w;
            end
            default: begin
                ack_w = 1'b0;
                nxt_w = qex_pkg::TS_IGN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte engine
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= qex_pkg::TS_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ack_ph_r <= 1'b0;
            data_ph_r <= 1'b0;
            sda_low_r <= 1'b0;
            nack_r <= 1'b0;
            pair_r <= 1'b0;
            id_idx_r <= 2'h0;
            gc_armed_r <= 1'b0;
            id_armed_r <= 1'b0;
        end else if (clr_w || stop_w) begin
            st_r <= qex_pkg::TS_IDLE;
            ack_ph_r <= 1'b0;
            sda_low_r <= 1'b0;
            gc_armed_r <= 1'b0;
            id_armed_r <= 1'b0;
        end else if (start_w) begin
            st_r <= qex_pkg::TS_ADDR;
            bit_r <= 4'h0;
            ack_ph_r <= 1'b0;
            data_ph_r <= 1'b0;
            sda_low_r <= 1'b0;
            gc_armed_r <= 1'b0;
        end else if (scl_rise_w && st_r != qex_pkg::TS_IDLE) begin
            if (bit_r < qex_pkg::ACK_BIT && !tx_st_w) begin
                sh_r <= {sh_r[6:0], sda_w};
                bit_r <= bit_r + 4'h1;
            end else begin
                nack_r <= sda_w;
            end
        end else if (ack_in_w) begin
            ack_ph_r <= 1'b1;
            if (tx_st_w) begin
                sda_low_r <= 1'b0;
            end else begin
                sda_low_r <= ack_w;
                st_r <= nxt_w;
                if (st_r == qex_pkg::TS_GC) begin
                    gc_armed_r <= ack_w;
                end
                if (st_r == qex_pkg::TS_ADDR || st_r == qex_pkg::TS_IDTGT) begin
                    id_armed_r <= (st_r == qex_pkg::TS_IDTGT) & own_hit_w;
                    pair_r <= 1'b0;
                    id_idx_r <= 2'h0;
                end
            end
        end else if (ack_end_w) begin
            ack_ph_r <= 1'b0;
            data_ph_r <= 1'b1;
            bit_r <= 4'h0;
            sda_low_r <= 1'b0;
            if (st_r == qex_pkg::TS_WR) begin
                pair_r <= pair_r ^ data_ph_r;
            end else if (tx_st_w && nack_r) begin
                st_r <= qex_pkg::TS_IDLE;
            end else if (tx_st_w) begin
                sda_low_r <= ~tx_byte_w[7];
                sh_r <= {tx_byte_w[6:0], 1'b0};
                bit_r <= 4'h1;
                pair_r <= ~pair_r;
                id_idx_r <= (id_idx_r == qex_pkg::ID_LAST) ? 2'h0 : id_idx_r + 2'h1;
            end
        end else if (scl_fall_w && tx_st_w && bit_r < qex_pkg::ACK_BIT) begin
            sda_low_r <= ~sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port latches and strong pull-up
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            port_r <= qex_pkg::PORT_RST;
            strong_r <= 16'h0000;
        end else if (clr_w) begin
            port_r <= qex_pkg::PORT_RST;
            strong_r <= 16'h0000;
        end else if (scl_fall_w) begin
            if (wr_evt_w) begin
                port_r <= pair_r ? {sh_r, port_r[7:0]} : {port_r[15:8], sh_r};
            end
            strong_r <= wr_evt_w ? wr_mask_w : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_port_o = port_r;
    assign o_port_oe_n = ~(~port_r | strong_r);
    assign o_strong_pullup = strong_r;
    assign bus.tgt_sda_o = 1'b0;
    assign bus.tgt_sda_oe_n = ~sda_low_r;

endmodule // qex_target

// ---- src/qex_pkg.sv ----
// constants and types shared by both ends of the quasi-bidirectional expander link
// assumes a 250 MHz core clock at both ends and an open-drain two-wire bus
package qex_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_NS = 4;
    localparam int SCL_NS = 1000;
    localparam int QTR_CYC = SCL_NS / (4 * CLK_NS);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // bus addresses and values
    localparam logic [7:0] GC_WR_BYTE = 8'h00;
    localparam logic [6:0] ID_ADDR = 7'h7c;
    localparam logic [7:0] SWRST_BYTE = 8'h06;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] ID_LAST = 2'h2;
    localparam logic [15:0] PORT_RST = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////////
    // controller registers
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_RXD = 8'h08;
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_NACK_BIT = 10;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        TS_IDLE = 4'h0,
        TS_ADDR = 4'h1,
        TS_GC = 4'h2,
        TS_WR = 4'h3,
        TS_RD = 4'h4,
        TS_IDTGT = 4'h5,
        TS_IDRD = 4'h6,
        TS_IGN = 4'h7
    } qex_tstate_t;

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP = 2'h1,
        OP_WRITE = 2'h2,
        OP_READ = 2'h3
    } qex_op_t;

endpackage

// ---- src/qex_if.sv ----
// open-drain two-wire bus between controller and expander
// assumes each end drives only its own enables; the wire levels are resolved here
`timescale 1ns/10ps
interface qex_if;
    logic scl;
    logic sda;
    logic ctrl_scl_o;
    logic ctrl_scl_oe_n;
    logic ctrl_sda_o;
    logic ctrl_sda_oe_n;
    logic tgt_sda_o;
    logic tgt_sda_oe_n;

    // wired-and with pull-ups
    assign scl = ctrl_scl_oe_n ? 1'b1 : ctrl_scl_o;
    assign sda = (ctrl_sda_oe_n ? 1'b1 : ctrl_sda_o) & (tgt_sda_oe_n ? 1'b1 : tgt_sda_o);

    modport ctrl (
        input scl,
        input sda,
        output ctrl_scl_o,
        output ctrl_scl_oe_n,
        output ctrl_sda_o,
        output ctrl_sda_oe_n
    );

    modport target (
        input scl,
        input sda,
        output tgt_sda_o,
        output tgt_sda_oe_n
    );
endinterface // qex_if

// ---- src/qex_ctrl.sv ----
// controller end: register-driven bit engine that makes scl and drives sda
// assumes software issues one command at a time and polls the busy bit
`timescale 1ns/10ps
module qex_ctrl (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // bus
    qex_if.ctrl bus,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // sda sampling
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic sda_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            s1_r <= bus.sda;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sda_r <= (s2_r == s3_r) ? s3_r : sda_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register decode
    logic busy_r;
    logic nack_r;
    logic [7:0] rxd_r;
    logic [31:0] rdata_r;
    logic cmd_wr_w;
    logic [31:0] rd_mux_w;

    assign cmd_wr_w = i_wr & (i_addr == qex_pkg::REG_CMD) & ~busy_r;
    assign rd_mux_w = (i_addr == qex_pkg::REG_STAT) ? {30'h0, nack_r, busy_r} :
                      (i_addr == qex_pkg::REG_RXD) ? {24'h0, rxd_r} : 32'h0;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= i_rd ? rd_mux_w : 32'h0;
        end
    end

    assign o_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // quarter-period divider
    logic [7:0] div_r;
    logic tick_w;

    assign tick_w = busy_r & (div_r == qex_pkg::QTR_LAST);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r <= 8'h00;
        end else begin
            div_r <= (tick_w || !busy_r) ? 8'h00 : div_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit engine
    qex_pkg::qex_op_t op_r;
    logic [1:0] q_r;
    logic [3:0] bi_r;
    logic [8:0] sh_r;
    logic [8:0] rx_r;
    logic scl_oe_n_r;
    logic sda_oe_n_r;
    logic byte_op_w;
    logic last_w;

    assign byte_op_w = (op_r == qex_pkg::OP_WRITE) | (op_r == qex_pkg::OP_READ);
    assign last_w = ~byte_op_w | (bi_r == qex_pkg::ACK_BIT);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            op_r <= qex_pkg::OP_STOP;
            q_r <= 2'h0;
            bi_r <= 4'h0;
            sh_r <= 9'h1ff;
            rx_r <= 9'h000;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
            rxd_r <= 8'h00;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else if (cmd_wr_w) begin
            op_r <= qex_pkg::qex_op_t'(i_wdata[qex_pkg::CMD_OP_LSB +: 2]);
            q_r <= 2'h0;
            bi_r <= 4'h0;
            busy_r <= 1'b1;
            sh_r <= (i_wdata[qex_pkg::CMD_OP_LSB +: 2] == qex_pkg::OP_WRITE) ?
                    {i_wdata[7:0], 1'b1} : {8'hff, i_wdata[qex_pkg::CMD_NACK_BIT]};
        end else if (tick_w) begin
            q_r <= q_r + 2'h1;
            case (q_r)
                2'h0: begin
                    sda_oe_n_r <= (op_r == qex_pkg::OP_START) ? 1'b1 :
                                  (op_r == qex_pkg::OP_STOP) ? 1'b0 : sh_r[8];
                end
                2'h1: begin
                    scl_oe_n_r <= 1'b1;
                end
                2'h2: begin
                    if (op_r == qex_pkg::OP_START) begin
                        sda_oe_n_r <= 1'b0;
                    end else if (op_r == qex_pkg::OP_STOP) begin
                        sda_oe_n_r <= 1'b1;
                    end else begin
                        rx_r <= {rx_r[7:0], sda_r};
                    end
                end
                default: begin
                    if (op_r != qex_pkg::OP_STOP) begin
                        scl_oe_n_r <= 1'b0;
                    end
                    sh_r <= {sh_r[7:0], 1'b1};
                    bi_r <= bi_r + 4'h1;
                    if (last_w) begin
                        busy_r <= 1'b0;
                        if (byte_op_w) begin
                            rxd_r <= rx_r[8:1];
                        end
                        if (op_r == qex_pkg::OP_WRITE) begin
                            nack_r <= rx_r[0];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus outputs
    assign bus.ctrl_scl_o = 1'b0;
    assign bus.ctrl_scl_oe_n = scl_oe_n_r;
    assign bus.ctrl_sda_o = 1'b0;
    assign bus.ctrl_sda_oe_n = sda_oe_n_r;

endmodule // qex_ctrl

// ---- dv/qex_properties.sv ----
// checker: bus and port properties of the expander end
// assumes it sits beside the bus interface, fed by the testbench top
`timescale 1ns/10ps
module qex_properties (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // bus wires and target enable
    input wire logic scl,
    input wire logic sda,
    input wire logic tgt_sda_oe_n,
    // target reset pin and port pins
    input wire logic i_reset_n,
    input wire logic [15:0] o_port_o,
    input wire logic [15:0] o_port_oe_n,
    input wire logic [15:0] o_strong_pullup
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////////
    chk_port_defaults: assert property ($fell(i_rst) |-> o_port_o == qex_pkg::PORT_RST
        && o_port_oe_n == 16'hffff && o_strong_pullup == 16'h0 && tgt_sda_oe_n)
        else $error("port outputs not at defaults after reset");
    chk_pin_reset_hold: assert property (!i_reset_n [*8] |-> o_port_o == qex_pkg::PORT_RST
        && o_strong_pullup == 16'h0 && tgt_sda_oe_n)
        else $error("reset pin low but defaults not held");
    chk_weak_drive: assert property (o_port_oe_n == (o_port_o & ~o_strong_pullup))
        else $error("pin drive enable does not follow latch and strong pull-up");
    chk_strong_only_high: assert property ((o_strong_pullup & ~o_port_o) == 16'h0)
        else $error("strong pull-up on a pin latched low");
    chk_strong_clears: assert property ($fell(scl) && o_strong_pullup != 16'h0
        |-> ##[1:10] o_strong_pullup == 16'h0)
        else $error("strong pull-up not cleared after scl fall");
    chk_port_on_low: assert property ($changed(o_port_o) && o_port_o != qex_pkg::PORT_RST
        |-> !scl)
        else $error("port latch changed while scl high");
    chk_sda_on_low: assert property ($changed(tgt_sda_oe_n) |-> !scl)
        else $error("target sda drive changed while scl high");
    chk_start_free: assert property (scl && $past(scl) && $fell(sda) |-> tgt_sda_oe_n)
        else $error("target pulled sda while scl high");
endmodule // qex_properties

// ---- dv/testbench.sv ----
// testbench: controller and expander joined over the bus interface
// assumes the register map and op codes of the shared package
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] MFR = 8'h3c; // arbitrary value
    localparam logic [12:0] PART = 13'h0a55; // arbitrary value
    localparam logic [2:0] REV = 3'h5; // arbitrary value
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_reset_n = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata;
    logic [15:0] i_port_in = 16'h0;
    logic [15:0] o_port_o;
    logic [15:0] o_port_oe_n;
    logic [15:0] o_strong_pullup;
    logic [6:0] own = 7'h20;
    logic [7:0] rxb, b0, b1, b2, b3;
    logic nk;
    int bad_count = 0;
    int num_checks = 0;
    qex_if bus_if();
    qex_ctrl i_qex_ctrl (.i_core_clk, .i_rst, .bus(bus_if.ctrl), .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata);
    qex_target #(.P_MFR_ID(MFR), .P_PART_ID(PART), .P_REV_ID(REV)) i_qex_target (.i_core_clk,
        .i_rst, .bus(bus_if.target), .i_own_addr(own), .i_reset_n, .i_port_in, .o_port_o,
        .o_port_oe_n, .o_strong_pullup);
    qex_properties i_qex_properties (.i_core_clk, .i_rst, .scl(bus_if.scl), .sda(bus_if.sda),
        .tgt_sda_oe_n(bus_if.tgt_sda_oe_n), .i_reset_n, .o_port_o, .o_port_oe_n,
        .o_strong_pullup);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] id_byte(input int k);
        logic [23:0] w;
        w = {MFR, PART, REV};
        return w[23 - 8 * (k % 3) -: 8];
    endfunction
    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // one bus command, polled until idle
    task automatic xfer(input qex_pkg::qex_op_t op, input logic [7:0] d, input logic nb);
        logic [31:0] st;
        int n;
        reg_wr(qex_pkg::REG_CMD, {21'h0, nb, op, d});
        for (n = 0; n < 3000; n++) begin
            reg_rd(qex_pkg::REG_STAT, st);
            if (st[qex_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 3000) begin
            bad_count++;
            results();
        end
        nk = st[qex_pkg::STAT_NACK_BIT];
        reg_rd(qex_pkg::REG_RXD, st);
        rxb = st[7:0];
    endtask
    task automatic sta();
        xfer(qex_pkg::OP_START, 8'h00, 1'b0);
    endtask
    task automatic sto();
        xfer(qex_pkg::OP_STOP, 8'h00, 1'b0);
    endtask
    task automatic wb(input logic [7:0] b, input logic e);
        xfer(qex_pkg::OP_WRITE, b, 1'b0);
        chk("nack", {31'h0, e}, {31'h0, nk});
    endtask
    task automatic rb(input logic nb, input logic [7:0] e);
        xfer(qex_pkg::OP_READ, 8'h00, nb);
        chk("rx", {24'h0, e}, {24'h0, rxb});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        logic [31:0] d;
        void'($urandom(32'h4c3d));
        own = {2'b01, 5'($urandom)};
        {b0, b1, b3} = 24'($urandom);
        b2 = 8'($urandom) & 8'hfe;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        chk("port", 32'h0000ffff, {16'h0, o_port_o});
        chk("oe", 32'h0000ffff, {16'h0, o_port_oe_n});
        reg_rd(8'h0c, d);
        chk("unmapped", 32'h0, d);
        sta();
        wb({own, 1'b0}, 1'b0);
        wb(b0, 1'b0);
        wb(b1, 1'b0);
        chk("port0", {24'h0, b0}, {24'h0, o_port_o[7:0]});
        wb(b2, 1'b0);
        chk("port1", {24'h0, b1}, {24'h0, o_port_o[15:8]});
        wb(b3, 1'b0);
        sto();
        chk("port", {16'h0, b3, b2}, {16'h0, o_port_o});
        @(posedge i_core_clk);
        i_port_in <= 16'($urandom);
        sta();
        wb({own, 1'b1}, 1'b0);
        rb(1'b0, i_port_in[7:0]);
        rb(1'b1, i_port_in[15:8]);
        sto();
        sta();
        wb(8'h01, 1'b1);
        sto();
        sta();
        wb(qex_pkg::GC_WR_BYTE, 1'b0);
        wb(8'h07, 1'b1);
        sto();
        sta();
        wb(qex_pkg::GC_WR_BYTE, 1'b0);
        wb(qex_pkg::SWRST_BYTE, 1'b0);
        wb(qex_pkg::SWRST_BYTE, 1'b1);
        sta();
        sto();
        chk("port", {16'h0, b3, b2}, {16'h0, o_port_o});
        sta();
        wb(qex_pkg::GC_WR_BYTE, 1'b0);
        wb(qex_pkg::SWRST_BYTE, 1'b0);
        sto();
        repeat (8) @(posedge i_core_clk);
        chk("port", 32'h0000ffff, {16'h0, o_port_o});
        sta();
        wb({qex_pkg::ID_ADDR, 1'b0}, 1'b0);
        wb({own, 1'b1}, 1'b0);
        sta();
        wb({qex_pkg::ID_ADDR, 1'b1}, 1'b0);
        for (int k = 0; k < 4; k++) begin
            rb(k == 3, id_byte(k));
        end
        sta();
        wb({qex_pkg::ID_ADDR, 1'b1}, 1'b1);
        sto();
        sta();
        wb({qex_pkg::ID_ADDR, 1'b0}, 1'b0);
        wb({own ^ 7'h01, 1'b0}, 1'b1);
        sto();
        sta();
        wb({qex_pkg::ID_ADDR, 1'b0}, 1'b0);
        wb({own, 1'b0}, 1'b0);
        sto();
        sta();
        wb({qex_pkg::ID_ADDR, 1'b1}, 1'b1);
        sto();
        sta();
        wb({own, 1'b0}, 1'b0);
        wb(b2, 1'b0);
        wb(8'hff, 1'b0);
        sto();
        chk("port", {16'h0, 8'hff, b2}, {16'h0, o_port_o});
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        chk("port", 32'h0000ffff, {16'h0, o_port_o});
        i_reset_n <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        results();
    end
endmodule // testbench
